/* File: design/capture_reset_enable_pkg.sv */
/*
 * Shared constants and field layouts of the 16-bit capture/reload timer.
 * Assumes an 8-bit register port whose addresses are the printed offsets.
 */
package capture_reset_enable_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'hc8;
	localparam logic [7:0] ADDR_MODE = 8'hc9;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [15:0] RESET_RELOAD = 16'h0000;
	localparam logic [15:0] RESET_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int PIN_TRIGGER = 0;
	localparam int PIN_COUNT = 1;
	localparam int EXT_INT_COUNT = 4;

	// control register, bit 7 first
	typedef struct packed {
		logic overflowFlag;
		logic externalEventFlag;
		logic receiveClockSelect;
		logic transmitClockSelect;
		logic externalTriggerEnable;
		logic runControl;
		logic counterTimerSelect;
		logic captureReloadSelect;
	} capture_reset_enable_control_t;

	// mode register, bit 7 first; bit 2 reads zero
	typedef struct packed {
		logic [3:0] autoClearExtInt;
		logic captureResetEnable;
		logic unused;
		logic clockOutputEnable;
		logic downCountEnable;
	} capture_reset_enable_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wr;
		logic rd;
	} capture_reset_enable_bus_t;
endpackage : capture_reset_enable_pkg

/* File: design/capture_reset_enable_timer.sv */
/*
 * Timer 2: 16-bit counter with capture, auto-reload, up/down counting,
 * clock output and baud tick generation for serial port 0.
 * Assumes pins arrive asynchronously; all other inputs share ref_clk.
 */
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module capture_reset_enable_timer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire capture_reset_enable_pkg::capture_reset_enable_bus_t bus,
	output logic [7:0] regRdData,
	input wire logic triggerInputPin,
	input wire logic countInputPin,
	input wire logic rateTick,
	input wire logic timer1Overflow,
	input wire logic timerIntEnable,
	output logic timerIntReq,
	output logic serialRxTick,
	output logic serialTxTick,
	output logic clockOut,
	output logic clockOutOe,
	input wire logic [3:0] extIntSet,
	input wire logic [3:0] extIntSwClear,
	input wire logic [3:0] extIntServiceEntry,
	output logic [3:0] extIntFlag
);
	// ==========================================================
	// pin synchronisers
	logic [1:0] pinRaw;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] pinLevel;
	logic [1:0] pinFall;

	assign pinRaw = {countInputPin, triggerInputPin};

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_pin
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1[gp] <= 1'b1;
					sync2[gp] <= 1'b1;
					sync3[gp] <= 1'b1;
					pinLevel[gp] <= 1'b1;
					pinFall[gp] <= 1'b0;
				end else begin
					sync1[gp] <= pinRaw[gp];
					sync2[gp] <= sync1[gp];
					sync3[gp] <= sync2[gp];
					// a change counts once two stages agree
					if (sync2[gp] == sync3[gp]) begin
						pinLevel[gp] <= sync3[gp];
					end
					pinFall[gp] <= (sync2[gp] == sync3[gp]) &&
						pinLevel[gp] && !sync3[gp];
				end
			end
		end
	endgenerate

	// ==========================================================
	// registers
	capture_reset_enable_pkg::capture_reset_enable_control_t ctrl;
	capture_reset_enable_pkg::capture_reset_enable_mode_t mode;
	logic [15:0] reload;
	logic [15:0] count;
	logic halfTick;

	logic baudMode;
	logic downMode;
	logic countUp;
	logic trigEvent;
	logic incEnable;
	logic atTop;
	logic atBottom;
	logic wrapEvent;
	logic setOverflow;
	logic setExternal;
	logic doCapture;
	logic [15:0] next_count;

	logic wrCtrl;
	logic wrMode;
	logic wrRelL;
	logic wrRelH;
	logic wrCntL;
	logic wrCntH;

	assign wrCtrl = bus.wr && bus.addr == capture_reset_enable_pkg::ADDR_CONTROL;
	assign wrMode = bus.wr && bus.addr == capture_reset_enable_pkg::ADDR_MODE;
	assign wrRelL = bus.wr && bus.addr == capture_reset_enable_pkg::ADDR_RELOAD_LOW;
	assign wrRelH = bus.wr && bus.addr == capture_reset_enable_pkg::ADDR_RELOAD_HIGH;
	assign wrCntL = bus.wr && bus.addr == capture_reset_enable_pkg::ADDR_COUNT_LOW;
	assign wrCntH = bus.wr && bus.addr == capture_reset_enable_pkg::ADDR_COUNT_HIGH;

	// ==========================================================
	// mode decode
	assign baudMode = ctrl.receiveClockSelect ||
		ctrl.transmitClockSelect;
	// up/down only in plain auto-reload mode
	assign downMode = mode.downCountEnable && !baudMode &&
		!ctrl.captureReloadSelect;
	assign countUp = !downMode || pinLevel[capture_reset_enable_pkg::PIN_TRIGGER];
	// in down mode the pin steers direction, not events
	assign trigEvent = pinFall[capture_reset_enable_pkg::PIN_TRIGGER] &&
		ctrl.externalTriggerEnable && !baudMode && !downMode;

	// ==========================================================
	// count rate
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			halfTick <= 1'b0;
		end else if (ctrl.runControl && baudMode) begin
			halfTick <= !halfTick;
		end else begin
			halfTick <= 1'b0;
		end
	end

	always_comb begin
		if (!ctrl.runControl) begin
			incEnable = 1'b0;
		end else if (baudMode) begin
			incEnable = halfTick;
		end else if (ctrl.counterTimerSelect) begin
			incEnable = pinFall[capture_reset_enable_pkg::PIN_COUNT];
		end else begin
			incEnable = rateTick;
		end
	end

	assign atTop = count == capture_reset_enable_pkg::COUNT_MAX;
	assign atBottom = count == reload;
	assign wrapEvent = incEnable && (countUp ? atTop : atBottom);
	assign doCapture = trigEvent && ctrl.captureReloadSelect;

	// ==========================================================
	// counter next value
	always_comb begin
		next_count = count;
		if (doCapture && mode.captureResetEnable) begin
			next_count = capture_reset_enable_pkg::RESET_COUNT;
		end else if (trigEvent && !ctrl.captureReloadSelect) begin
			next_count = reload;
		end else if (incEnable) begin
			if (!countUp) begin
				// leaving the reload value wraps to the top
				next_count = atBottom ? capture_reset_enable_pkg::COUNT_MAX :
					count - 16'h0001;
			end else if (atTop && (baudMode ||
					!ctrl.captureReloadSelect)) begin
				next_count = reload;
			end else begin
				next_count = count + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= capture_reset_enable_pkg::RESET_COUNT;
		end else begin
			count <= next_count;
			if (wrCntL) begin
				count[7:0] <= bus.wrData;
			end
			if (wrCntH) begin
				count[15:8] <= bus.wrData;
			end
		end
	end

	// ==========================================================
	// capture / reload value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload <= capture_reset_enable_pkg::RESET_RELOAD;
		end else begin
			if (doCapture) begin
				reload <= count;
			end
			if (wrRelL) begin
				reload[7:0] <= bus.wrData;
			end
			if (wrRelH) begin
				reload[15:8] <= bus.wrData;
			end
		end
	end

	// ==========================================================
	// control and mode registers
	assign setOverflow = wrapEvent && !baudMode;
	assign setExternal = trigEvent ||
		(wrapEvent && downMode);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= capture_reset_enable_pkg::RESET_CONTROL;
		end else begin
			if (wrCtrl) begin
				ctrl <= bus.wrData;
			end
			// hardware set wins over a software clear
			if (setOverflow) begin
				ctrl.overflowFlag <= 1'b1;
			end
			if (setExternal) begin
				ctrl.externalEventFlag <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= capture_reset_enable_pkg::RESET_MODE;
		end else if (wrMode) begin
			mode <= bus.wrData;
			mode.unused <= 1'b0;
		end
	end

	// ==========================================================
	// outputs toward serial port, clock pin and interrupt
	logic wrapPulse;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrapPulse <= 1'b0;
			clockOut <= 1'b0;
			timerIntReq <= 1'b0;
		end else begin
			wrapPulse <= wrapEvent;
			if (!mode.clockOutputEnable) begin
				clockOut <= 1'b0;
			end else if (wrapEvent) begin
				clockOut <= !clockOut;
			end
			timerIntReq <= timerIntEnable && (ctrl.overflowFlag ||
				ctrl.externalEventFlag ||
				pinFall[capture_reset_enable_pkg::PIN_TRIGGER]);
		end
	end

	assign clockOutOe = mode.clockOutputEnable;
	assign serialRxTick = ctrl.receiveClockSelect ? wrapPulse :
		timer1Overflow;
	assign serialTxTick = ctrl.transmitClockSelect ? wrapPulse :
		timer1Overflow;

	// ==========================================================
	// external interrupt 2-5 flags
	genvar gi;
	generate
		for (gi = 0; gi < capture_reset_enable_pkg::EXT_INT_COUNT; gi++) begin : g_ext
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					extIntFlag[gi] <= 1'b0;
				end else if (extIntSet[gi]) begin
					extIntFlag[gi] <= 1'b1;
				end else if (extIntSwClear[gi] ||
						(extIntServiceEntry[gi] &&
						mode.autoClearExtInt[gi])) begin
					extIntFlag[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// register read port
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= capture_reset_enable_pkg::READ_UNMAPPED;
		end else if (bus.rd) begin
			unique case (bus.addr)
				capture_reset_enable_pkg::ADDR_CONTROL: regRdData <= ctrl;
				capture_reset_enable_pkg::ADDR_MODE: regRdData <= mode;
				capture_reset_enable_pkg::ADDR_RELOAD_LOW: regRdData <= reload[7:0];
				capture_reset_enable_pkg::ADDR_RELOAD_HIGH: regRdData <= reload[15:8];
				capture_reset_enable_pkg::ADDR_COUNT_LOW: regRdData <= count[7:0];
				capture_reset_enable_pkg::ADDR_COUNT_HIGH: regRdData <= count[15:8];
				default: regRdData <= capture_reset_enable_pkg::READ_UNMAPPED;
			endcase
		end
	end
endmodule : capture_reset_enable_timer
`default_nettype wire

/* File: sim/capture_reset_enable_timer_monitor.sv */
/*
 * Port-level assertions for the capture/reload timer.
 * Assumes it is bound onto capture_reset_enable_timer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module capture_reset_enable_timer_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire capture_reset_enable_pkg::capture_reset_enable_bus_t bus,
	input wire logic [7:0] regRdData,
	input wire logic timer1Overflow,
	input wire logic timerIntEnable,
	input wire logic timerIntReq,
	input wire logic serialRxTick,
	input wire logic serialTxTick,
	input wire logic clockOut,
	input wire logic clockOutOe,
	input wire logic [3:0] extIntSet,
	input wire logic [3:0] extIntServiceEntry,
	input wire logic [3:0] extIntFlag
);
	logic rxSel;
	logic txSel;
	logic [3:0] autoClr;
	logic [3:0] clrNow;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ========================================
	// software-only bits mirrored from writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxSel <= 1'b0;
			txSel <= 1'b0;
			autoClr <= 4'h0;
		end else if (bus.wr && bus.addr == 8'hc8) begin
			rxSel <= bus.wrData[5];
			txSel <= bus.wrData[4];
		end else if (bus.wr && bus.addr == 8'hc9) begin
			autoClr <= bus.wrData[7:4];
		end
	end
	assign clrNow = extIntServiceEntry & autoClr & ~extIntSet;
	// ========================================
	// assertions
	int_gate_a: assert property (timerIntReq |-> $past(timerIntEnable))
		else $error("interrupt request without enable");
	rx_source_a: assert property (!rxSel |-> serialRxTick == timer1Overflow)
		else $error("receive tick not from timer 1");
	tx_source_a: assert property (!txSel |-> serialTxTick == timer1Overflow)
		else $error("transmit tick not from timer 1");
	baud_pace_a: assert property (rxSel && serialRxTick && !bus.wr |=> !serialRxTick)
		else $error("baud ticks closer than 2 clocks");
	clk_out_off_a: assert property (!$past(clockOutOe) |-> !clockOut)
		else $error("clock output active while disabled");
	oe_follows_a: assert property (bus.wr && bus.addr == 8'hc9 |=>
		clockOutOe == $past(bus.wrData[1]))
		else $error("output enable not taken from mode write");
	ext_set_a: assert property (|extIntSet |=>
		(extIntFlag & $past(extIntSet)) == $past(extIntSet))
		else $error("external flag not set");
	auto_clear_a: assert property (|clrNow |=> (extIntFlag & $past(clrNow)) == 4'h0)
		else $error("external flag not cleared on entry");
	mode_gap_a: assert property (bus.rd && bus.addr == 8'hc9 |=> !regRdData[2])
		else $error("mode bit 2 reads one");
	cover property (rxSel && serialRxTick);
	cover property (timerIntReq);
	cover property (|clrNow);
endmodule : capture_reset_enable_timer_monitor
`default_nettype wire

/* File: sim/capture_reset_enable_pin_model.sv */
/*
 * Far-side pins: trigger level and a count pin that toggles on demand.
 * Assumes the bench holds each trigger level for many cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module capture_reset_enable_pin_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic trigHigh,
	input wire logic countEn,
	output logic triggerInputPin,
	output logic countInputPin
);
	logic [1:0] phase;
	// each level lasts 4 clocks, longer than the pin synchroniser needs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 2'h0;
			countInputPin <= 1'b1;
		end else begin
			phase <= phase + 2'h1;
			if (countEn && phase == 2'h3) countInputPin <= !countInputPin;
		end
	end
	assign triggerInputPin = trigHigh;
endmodule : capture_reset_enable_pin_model
`default_nettype wire

/* File: sim/tb_timer2_capture_reload.sv */
/*
 * Self-checking bench for the capture/reload timer.
 * Assumes the package, the timer, the pin model and the monitor.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_timer2_capture_reload;
	logic ref_clk, rst_n, rateTick, timer1Overflow, timerIntEnable;
	logic timerIntReq, serialRxTick, serialTxTick, clockOut, clockOutOe;
	logic trigHigh, countEn, triggerInputPin, countInputPin;
	logic [3:0] extIntSet, extIntSwClear, extIntServiceEntry, extIntFlag, rnd;
	logic [7:0] regRdData;
	logic [15:0] r, c;
	capture_reset_enable_pkg::capture_reset_enable_bus_t bus;
	int n_mismatch = 0;
	int tests_run = 0;
	int falls, n, k;
	capture_reset_enable_timer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
		.regRdData(regRdData), .triggerInputPin(triggerInputPin),
		.countInputPin(countInputPin), .rateTick(rateTick),
		.timer1Overflow(timer1Overflow), .timerIntEnable(timerIntEnable),
		.timerIntReq(timerIntReq), .serialRxTick(serialRxTick),
		.serialTxTick(serialTxTick), .clockOut(clockOut),
		.clockOutOe(clockOutOe), .extIntSet(extIntSet),
		.extIntSwClear(extIntSwClear),
		.extIntServiceEntry(extIntServiceEntry), .extIntFlag(extIntFlag));
	capture_reset_enable_pin_model i_pins (.ref_clk(ref_clk), .rst_n(rst_n),
		.trigHigh(trigHigh), .countEn(countEn),
		.triggerInputPin(triggerInputPin), .countInputPin(countInputPin));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) timer1Overflow <= 1'($urandom % 2);
	always @(negedge countInputPin) falls++;
	// ========================================
	// bus and check tasks
	task chk(string nm, logic [15:0] e, logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask : wr
	task rd(logic [7:0] a, logic [7:0] e);
		@(posedge ref_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 chk("read data", {8'h00, e}, {8'h00, regRdData});
	endtask : rd
	task rd16(logic [7:0] a, logic [15:0] e);
		rd(a, e[7:0]);
		rd(a + 8'h01, e[15:8]);
	endtask : rd16
	task wr16(logic [7:0] a, logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 8'h01, d[15:8]);
	endtask : wr16
	task tick(int t);
		repeat (t) begin
			@(posedge ref_clk);
			rateTick <= 1'b1;
			@(posedge ref_clk);
			rateTick <= 1'b0;
		end
	endtask : tick
	task trig(logic lvl);
		@(posedge ref_clk);
		trigHigh <= lvl;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask : trig
	task test_done;
		$display("mismatches %0d, checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	initial begin
		#(50 * 4000);
		n_mismatch++;
		test_done();
	end
	// ========================================
	// scenarios
	initial begin
		void'($urandom(47));
		{rst_n, rateTick, timerIntEnable, countEn} = 4'h0;
		{extIntSet, extIntSwClear, extIntServiceEntry} = 12'h000;
		bus = '0;
		trigHigh = 1'b1;
		r = 16'($urandom % 32768);
		c = 16'($urandom);
		rnd = 4'($urandom);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (k = 8'hc7; k <= 8'hcd; k++) rd(8'(k), 8'h00);
		wr(8'hc9, 8'hff);
		rd(8'hc9, 8'hfb);
		chk("clock output enable", 16'h1, {15'h0, clockOutOe});
		wr(8'hc9, 8'h00);
		wr16(8'hca, r);
		wr16(8'hcc, 16'hfffe);
		wr(8'hc8, 8'h04);
		tick(2);
		rd16(8'hcc, r);
		rd(8'hc8, 8'h84);
		tick(1);
		wr(8'hc8, 8'h00);
		tick(3);
		rd16(8'hcc, r + 16'h1);
		wr(8'hc9, 8'h01);
		wr16(8'hcc, 16'hffff);
		wr(8'hc8, 8'h04);
		tick(1);
		rd16(8'hcc, r);
		rd(8'hc8, 8'hc4);
		trig(1'b0);
		wr(8'hc8, 8'h04);
		wr16(8'hcc, r + 16'h1);
		tick(2);
		rd16(8'hcc, 16'hffff);
		rd(8'hc8, 8'hc4);
		trig(1'b1);
		wr(8'hc9, 8'h08);
		wr16(8'hcc, c);
		timerIntEnable <= 1'b1;
		wr(8'hc8, 8'h0f);
		trig(1'b0);
		chk("interrupt request", 16'h1, {15'h0, timerIntReq});
		rd16(8'hca, c);
		rd16(8'hcc, 16'h0000);
		rd(8'hc8, 8'h4f);
		falls = 0;
		countEn <= 1'b1;
		repeat (40) @(posedge ref_clk);
		countEn <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rd16(8'hcc, 16'(falls));
		trig(1'b1);
		wr16(8'hca, 16'hffff);
		// start at the top so every second clock wraps
		wr16(8'hcc, 16'hffff);
		wr(8'hc8, 8'h3d);
		trigHigh <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge ref_clk);
			#1 n += int'(serialRxTick);
		end
		chk("baud ticks", 16'h1, {15'h0, n >= 19 && n <= 21});
		rd(8'hc8, 8'h3d);
		rd16(8'hca, 16'hffff);
		wr(8'hc9, {rnd, 4'h0});
		extIntSet <= 4'hf;
		@(posedge ref_clk);
		extIntSet <= 4'h0;
		extIntServiceEntry <= 4'hf;
		@(posedge ref_clk);
		extIntServiceEntry <= 4'h0;
		@(posedge ref_clk);
		#1 chk("external flags", {12'h000, ~rnd}, {12'h000, extIntFlag});
		test_done();
	end
endmodule : tb_timer2_capture_reload
bind capture_reset_enable_timer capture_reset_enable_timer_monitor i_mon (.ref_clk(ref_clk), .rst_n(rst_n),
	.bus(bus), .regRdData(regRdData), .timer1Overflow(timer1Overflow),
	.timerIntEnable(timerIntEnable), .timerIntReq(timerIntReq),
	.serialRxTick(serialRxTick), .serialTxTick(serialTxTick),
	.clockOut(clockOut), .clockOutOe(clockOutOe), .extIntSet(extIntSet),
	.extIntServiceEntry(extIntServiceEntry), .extIntFlag(extIntFlag));
`default_nettype wire
